/* include/slpr_core_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface slpr_core_if;
    import slpr_pkg::*;
    logic wr_stb;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] wdat;
    logic [REG_W-1:0] rdat;
    logic [K_W-1:0] k_code;
    logic [N_W-1:0] n_code;
    logic [REG_W-1:0] f_code;
    logic k_ok;
    logic n_ok;
    logic fk_ok;
    logic [5:0] k_frames;
    logic [5:0] n_bits;
    modport bus_side(output wr_stb, output idx, output wdat, input rdat);
    modport chk_side(input k_code, input n_code, input f_code,
                     output k_ok, output n_ok, output fk_ok, output k_frames, output n_bits);
    modport core(input wr_stb, input idx, input wdat, output rdat,
                 output k_code, output n_code, output f_code,
                 input k_ok, input n_ok, input fk_ok, input k_frames, input n_bits);
endinterface
`default_nettype wire

/* include/slpr_pkg.sv */
package slpr_pkg;
    localparam int unsigned ADR_W = 16;
    localparam int unsigned IDX_W = 12;
    localparam int unsigned DAT_W = 32;
    localparam int unsigned REG_W = 8;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_LANE = 12'h58B;
    localparam logic [IDX_W-1:0] IDX_F = 12'h58C;
    localparam logic [IDX_W-1:0] IDX_K = 12'h58D;
    localparam logic [IDX_W-1:0] IDX_M = 12'h58E;
    localparam logic [IDX_W-1:0] IDX_CSN = 12'h58F;
    localparam logic [IDX_W-1:0] IDX_STATUS = 12'h5C0;

    // Field positions
    localparam int unsigned LANE_LSB = 0;
    localparam int unsigned LANE_W = 5;
    localparam int unsigned K_LSB = 0;
    localparam int unsigned K_W = 5;
    localparam int unsigned CS_LSB = 6;
    localparam int unsigned CS_W = 2;
    localparam int unsigned N_LSB = 0;
    localparam int unsigned N_W = 5;
    localparam int unsigned ST_K_OK = 0;
    localparam int unsigned ST_N_OK = 1;
    localparam int unsigned ST_FK_OK = 2;

    // Reset values
    localparam logic [REG_W-1:0] RST_LANE = 8'h01;
    localparam logic [REG_W-1:0] RST_F = 8'h01;
    localparam logic [REG_W-1:0] RST_K = 8'h1F;
    localparam logic [REG_W-1:0] RST_M = 8'h01;
    localparam logic [REG_W-1:0] RST_CSN = 8'h0F;

    // Supported code ranges
    localparam logic [K_W-1:0] K_MIN_CODE = 5'h03;
    localparam logic [K_W-1:0] K_MAX_CODE = 5'h1F;
    localparam logic [1:0] K_STEP_LOW = 2'h3;
    localparam logic [N_W-1:0] N_MIN_CODE = 5'h06;
    localparam logic [N_W-1:0] N_MAX_CODE = 5'h0F;

    typedef enum logic {
        SLPR_IDLE,
        SLPR_ACK
    } slpr_bus_state_t;
endpackage

/* verification/slpr_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module slpr_regs_props #(
    parameter int unsigned LANE_COUNT = 2,
    parameter int unsigned OCTETS_PER_FRAME = 2,
    parameter int unsigned CONVERTER_COUNT = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [1:0] link_lanes_o,
    input wire logic [8:0] link_octets_per_frame_o,
    input wire logic [5:0] link_frames_per_multiframe_o,
    input wire logic [2:0] link_converters_o,
    input wire logic [1:0] link_control_bits_o,
    input wire logic [2:0] link_control_bit_mask_o,
    input wire logic [5:0] link_resolution_o,
    input wire logic link_config_ok_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    wire logic [5:0] frm = link_frames_per_multiframe_o;
    wire logic [5:0] res = link_resolution_o;
    ack_pulse_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");
    k_write_a: assert property (wr && wb_adr_i == 16'h1634 |-> ##2
        frm == {1'b0, $past(wb_dat_i[4:0], 2)} + 6'h01) else $error("frame count wrong");
    n_write_a: assert property (wr && wb_adr_i == 16'h163C |-> ##2
        res == {1'b0, $past(wb_dat_i[4:0], 2)} + 6'h01
        && link_control_bits_o == $past(wb_dat_i[7:6], 2)) else $error("resolution wrong");
    cs_mask_a: assert property (link_control_bit_mask_o == {link_control_bits_o != 2'h0,
        link_control_bits_o[1], link_control_bits_o == 2'h3}) else $error("mask wrong");
    lanes_ro_a: assert property (!$past(rst_i) |-> link_lanes_o == LANE_COUNT)
        else $error("lane count changed");
    octets_ro_a: assert property (!$past(rst_i) |-> link_octets_per_frame_o == OCTETS_PER_FRAME)
        else $error("octet count changed");
    conv_ro_a: assert property (!$past(rst_i) |-> link_converters_o == CONVERTER_COUNT)
        else $error("converter count changed");
    rd_oct_a: assert property (req && !wb_we_i && wb_adr_i == 16'h1630
        |=> wb_dat_o == OCTETS_PER_FRAME - 1) else $error("octet readback wrong");
    cfg_ok_a: assert property (!$past(rst_i) |-> link_config_ok_o == (frm[1:0] == 2'h0
        && res >= 6'h07 && res <= 6'h10 && (link_octets_per_frame_o * frm) % 4 == 0))
        else $error("config ok flag wrong");
    cover property (wr && wb_adr_i == 16'h1634);
    cover property (wr && wb_adr_i == 16'h163C);
    cover property (req && !wb_we_i);
endmodule
bind slpr_regs slpr_regs_props #(.LANE_COUNT(LANE_COUNT), .OCTETS_PER_FRAME(OCTETS_PER_FRAME),
    .CONVERTER_COUNT(CONVERTER_COUNT)) u_props (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .link_lanes_o(link_lanes_o), .link_octets_per_frame_o(link_octets_per_frame_o),
    .link_frames_per_multiframe_o(link_frames_per_multiframe_o),
    .link_converters_o(link_converters_o), .link_control_bits_o(link_control_bits_o),
    .link_control_bit_mask_o(link_control_bit_mask_o),
    .link_resolution_o(link_resolution_o), .link_config_ok_o(link_config_ok_o));
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import slpr_pkg::*;
    localparam int unsigned LN = 1;
    localparam int unsigned OC = 1;
    localparam int unsigned CV = 4;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ok;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wdat = 32'h0, rdat;
    logic [3:0] sel = 4'h0;
    logic [1:0] lanes, cbits;
    logic [8:0] oct;
    logic [5:0] frm, res;
    logic [2:0] conv, mask;
    logic [7:0] d, kreg, nreg;
    logic [2:0] mtab [4] = '{3'h0, 3'h4, 3'h6, 3'h7};
    logic [15:0] ro_a [3] = '{16'h162C, 16'h1630, 16'h1638};
    logic [31:0] ro_e [3] = '{32'(LN - 1), 32'(OC - 1), 32'h3};
    logic [2:0] st_e;
    logic [31:0] expq [$];
    int err_total = 0, total_checks = 0, seed = 32'h0ed9;
    slpr_regs #(.LANE_COUNT(LN), .OCTETS_PER_FRAME(OC), .CONVERTER_COUNT(CV)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .link_lanes_o(lanes), .link_octets_per_frame_o(oct),
        .link_frames_per_multiframe_o(frm), .link_converters_o(conv),
        .link_control_bits_o(cbits), .link_control_bit_mask_o(mask),
        .link_resolution_o(res), .link_config_ok_o(ok));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Full classic cycle; waits for ack under a bound
    task bus(input logic w, input logic [15:0] a, input logic [31:0] dt, input logic [3:0] s);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dt;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            err_total++;
            finish_test;
        end else begin
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task rd(input logic [15:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0, 4'hF);
    endtask
    // Decoded outputs against the bench copy of K and CS/N
    task outs;
        #1;
        check(32'(frm), 32'(kreg[4:0]) + 1);
        check(32'(res), 32'(nreg[4:0]) + 1);
        check(32'(cbits), 32'(nreg[7:6]));
        check(32'(mask), 32'(mtab[nreg[7:6]]));
        check(32'(ok), 32'(kreg[1:0] == 2'h3 && nreg[4:0] >= 5'h06 && nreg[4:0] <= 5'h0F));
        check({lanes, oct, conv}, {2'(LN), 9'(OC), 3'(CV)});
        @(posedge clk_i);
    endtask
    // Read results are paired with the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) check(rdat, expq.pop_front());
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        kreg = 8'h1F;
        nreg = 8'h0F;
        repeat (2) @(posedge clk_i);
        outs;
        rd(16'h1634, 32'h1F);
        rd(16'h163C, 32'h0F);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, ro_a[i], 32'($random(seed)), 4'hF);
            rd(ro_a[i], ro_e[i]);
        end
        for (int i = 0; i < 9; i++) begin
            d = 8'($random(seed));
            // Supported K codes only; with F of one, K must itself be a multiple of four
            // Legal K only
            if (i < 8) begin
                d[4:0] = 5'(4 * i + 3);
            end else begin
                d[1:0] = 2'h3;
            end
            bus(1'b1, 16'h1634, {24'($random(seed)), d}, 4'h1);
            kreg = {3'h0, d[4:0]};
            rd(16'h1634, 32'(kreg));
            outs;
        end
        // Last pass leaves N on an unsupported code so the ok flag must drop
        for (int i = 0; i < 5; i++) begin
            d = {2'(i), 1'($random(seed)), 5'(6 + 3 * i)};
            bus(1'b1, 16'h163C, 32'(d), 4'hF);
            nreg = {d[7:6], 1'b0, d[4:0]};
            rd(16'h163C, 32'(nreg));
            st_e[2] = (OC * (kreg[4:0] + 1)) % 4 == 0;
            st_e[1] = nreg[4:0] >= 5'h06 && nreg[4:0] <= 5'h0F;
            st_e[0] = kreg[1:0] == 2'h3;
            rd(16'h1700, 32'(st_e));
            outs;
        end
        bus(1'b1, 16'h1634, 32'h5, 4'hE);
        rd(16'h1634, 32'(kreg));
        bus(1'b1, 16'h0000, 32'hFF, 4'hF);
        rd(16'h0000, 32'h0);
        outs;
        finish_test;
    end
endmodule
`default_nettype wire

/* verilog/slpr_field_check.sv */
`timescale 1ns/1ps
`default_nettype none
module slpr_field_check (
    slpr_core_if.chk_side chk
);
    import slpr_pkg::*;

    wire [8:0] f_octets = {1'b0, chk.f_code} + 9'h001;
    wire [5:0] k_frm = {1'b0, chk.k_code} + 6'h01;
    wire [14:0] fk_product = f_octets * {3'h0, k_frm};

    assign chk.k_frames = k_frm;
    assign chk.n_bits = {1'b0, chk.n_code} + 6'h01;
    // Only codes 3, 7, ... 31 give K in steps of four
    assign chk.k_ok = (chk.k_code >= K_MIN_CODE) && (chk.k_code <= K_MAX_CODE)
                      && (chk.k_code[1:0] == K_STEP_LOW);
    assign chk.n_ok = (chk.n_code >= N_MIN_CODE) && (chk.n_code <= N_MAX_CODE);
    assign chk.fk_ok = (fk_product[1:0] == 2'h0);
endmodule
`default_nettype wire

/* verilog/slpr_regs.sv */
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Lane field reads 0x0 for one lane, 0x1 for two; read-only.
// - Octets-per-frame register is read-only; F is stored value plus one.
// - K field is writable, K is value plus one, codes 3 to 31 step four.
// - Converter field reads 0000000, 0000001, 00000011 for one, two, four converters.
// - CS field selects none, bit 2, bits 2-1, or bits 2-1-0 control bits.
// - Writable N field gives N as value plus one, codes 6 to 15.
module slpr_regs #(
    parameter int unsigned LANE_COUNT = 2,
    parameter int unsigned OCTETS_PER_FRAME = 2,
    parameter int unsigned CONVERTER_COUNT = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [slpr_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [slpr_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [slpr_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [1:0] link_lanes_o,
    output logic [8:0] link_octets_per_frame_o,
    output logic [5:0] link_frames_per_multiframe_o,
    output logic [2:0] link_converters_o,
    output logic [1:0] link_control_bits_o,
    output logic [2:0] link_control_bit_mask_o,
    output logic [5:0] link_resolution_o,
    output logic link_config_ok_o
);
    import slpr_pkg::*;

    // Lane count to field code
    function automatic logic [REG_W-1:0] lane_code(input int unsigned lanes);
        lane_code = (lanes == 2) ? 8'h01 : 8'h00;
    endfunction

    // Converter count to field code
    function automatic logic [REG_W-1:0] conv_code(input int unsigned convs);
        case (convs)
            2: conv_code = 8'h01;
            4: conv_code = 8'h03;
            default: conv_code = 8'h00;
        endcase
    endfunction

    // Control-bit count to enabled bit mask
    function automatic logic [2:0] cs_mask(input logic [CS_W-1:0] cs);
        case (cs)
            2'h1: cs_mask = 3'h4;
            2'h2: cs_mask = 3'h6;
            2'h3: cs_mask = 3'h7;
            default: cs_mask = 3'h0;
        endcase
    endfunction

    localparam logic [REG_W-1:0] LANE_FIXED = lane_code(LANE_COUNT);
    localparam logic [REG_W-1:0] F_FIXED = REG_W'(OCTETS_PER_FRAME - 1);
    localparam logic [REG_W-1:0] M_FIXED = conv_code(CONVERTER_COUNT);

    slpr_core_if cif ();

    slpr_wb_slave u_wb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .bus(cif.bus_side)
    );

    slpr_field_check u_chk (
        .chk(cif.chk_side)
    );

    logic [LANE_W-1:0] lane_r;
    logic [REG_W-1:0] f_r;
    logic [K_W-1:0] k_r;
    logic [REG_W-1:0] m_r;
    logic [CS_W-1:0] cs_r;
    logic [N_W-1:0] n_r;
    logic [LANE_W-1:0] lane_nxt;
    logic [REG_W-1:0] f_nxt;
    logic [K_W-1:0] k_nxt;
    logic [REG_W-1:0] m_nxt;
    logic [CS_W-1:0] cs_nxt;
    logic [N_W-1:0] n_nxt;

    logic [1:0] lanes_out_r;
    logic [8:0] octets_out_r;
    logic [5:0] frames_out_r;
    logic [2:0] convs_out_r;
    logic [1:0] cs_out_r;
    logic [2:0] mask_out_r;
    logic [5:0] res_out_r;
    logic ok_out_r;

    wire wr_k = cif.wr_stb && (cif.idx == IDX_K);
    wire wr_csn = cif.wr_stb && (cif.idx == IDX_CSN);

    // Read-only: fixed by link mode, reloaded by reset
    // Lane code
    assign lane_nxt = lane_r;
    assign f_nxt = f_r;
    assign m_nxt = m_r;
    assign k_nxt = wr_k ? cif.wdat[K_LSB +: K_W] : k_r;
    assign cs_nxt = wr_csn ? cif.wdat[CS_LSB +: CS_W] : cs_r;
    assign n_nxt = wr_csn ? cif.wdat[N_LSB +: N_W] : n_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_r <= LANE_FIXED[LANE_W-1:0];
            f_r <= F_FIXED;
            k_r <= RST_K[K_LSB +: K_W];
            m_r <= M_FIXED;
            cs_r <= RST_CSN[CS_LSB +: CS_W];
            n_r <= RST_CSN[N_LSB +: N_W];
        end else begin
            lane_r <= lane_nxt;
            f_r <= f_nxt;
            k_r <= k_nxt;
            m_r <= m_nxt;
            cs_r <= cs_nxt;
            n_r <= n_nxt;
        end
    end

    assign cif.k_code = k_r;
    assign cif.n_code = n_r;
    assign cif.f_code = f_r;

    // Read mux; reserved bits and unmapped slots read zero
    wire [REG_W-1:0] rd_lane = {{(REG_W-LANE_W){1'b0}}, lane_r};
    wire [REG_W-1:0] rd_k = {{(REG_W-K_W){1'b0}}, k_r};
    wire [REG_W-1:0] rd_csn = {cs_r, 1'b0, n_r};
    wire [REG_W-1:0] rd_status = {5'h00, cif.fk_ok, cif.n_ok, cif.k_ok};
    assign cif.rdat = (cif.idx == IDX_LANE) ? rd_lane :
                      (cif.idx == IDX_F) ? f_r :
                      (cif.idx == IDX_K) ? rd_k :
                      (cif.idx == IDX_M) ? m_r :
                      (cif.idx == IDX_CSN) ? rd_csn :
                      (cif.idx == IDX_STATUS) ? rd_status : 8'h00;

    // Decoded link settings, one cycle behind the registers
    wire [1:0] lanes_dec = lane_r[0] ? 2'h2 : 2'h1;
    wire [2:0] convs_dec = (m_r == 8'h03) ? 3'h4 : (m_r == 8'h01) ? 3'h2 : 3'h1;
    // belongs to software; the block flags a bad K code, a bad N code or a bad F x K
    wire ok_dec = cif.k_ok & cif.n_ok & cif.fk_ok;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lanes_out_r <= '0;
            octets_out_r <= '0;
            frames_out_r <= '0;
            convs_out_r <= '0;
            cs_out_r <= '0;
            mask_out_r <= '0;
            res_out_r <= '0;
            ok_out_r <= 1'b0;
        end else begin
            lanes_out_r <= lanes_dec;
            octets_out_r <= {1'b0, f_r} + 9'h001;
            frames_out_r <= cif.k_frames;
            convs_out_r <= convs_dec;
            cs_out_r <= cs_r;
            mask_out_r <= cs_mask(cs_r);
            res_out_r <= cif.n_bits;
            ok_out_r <= ok_dec;
        end
    end

    assign link_lanes_o = lanes_out_r;
    assign link_octets_per_frame_o = octets_out_r;
    assign link_frames_per_multiframe_o = frames_out_r;
    assign link_converters_o = convs_out_r;
    assign link_control_bits_o = cs_out_r;
    assign link_control_bit_mask_o = mask_out_r;
    assign link_resolution_o = res_out_r;
    assign link_config_ok_o = ok_out_r;
endmodule
`default_nettype wire

/* verilog/slpr_wb_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module slpr_wb_slave (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [slpr_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [slpr_pkg::DAT_W-1:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [slpr_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    slpr_core_if.bus_side bus
);
    import slpr_pkg::*;

    slpr_bus_state_t state_r;
    slpr_bus_state_t state_nxt;
    logic [DAT_W-1:0] dat_r;
    logic [DAT_W-1:0] dat_nxt;
    wire req = wb_cyc_i & wb_stb_i;
    wire aligned = (wb_adr_i[1:0] == 2'h0);

    // Index only on aligned words; misaligned goes to an unmapped slot
    assign bus.idx = aligned ? wb_adr_i[IDX_W+1:2] : '0;
    assign bus.wdat = wb_dat_i[REG_W-1:0];
    // Write lands on the edge where the master sees ack
    assign bus.wr_stb = (state_r == SLPR_ACK) & req & wb_we_i & wb_sel_i[0] & aligned;
    assign wb_ack_o = (state_r == SLPR_ACK);
    assign wb_dat_o = dat_r;

    always_comb begin
        state_nxt = state_r;
        dat_nxt = dat_r;
        case (state_r)
            SLPR_IDLE: begin
                if (req) begin
                    state_nxt = SLPR_ACK;
                    dat_nxt = {{(DAT_W-REG_W){1'b0}}, bus.rdat};
                end
            end
            SLPR_ACK: begin
                // Always one ack cycle; master drops the request after it
                state_nxt = SLPR_IDLE;
            end
            default: begin
                state_nxt = SLPR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= SLPR_IDLE;
            dat_r <= '0;
        end else begin
            state_r <= state_nxt;
            dat_r <= dat_nxt;
        end
    end
endmodule
`default_nettype wire
